/* hdl/nsb_pkg.sv */
// Package of offsets, fields, reset values and timing counts for the nibble register bank.
package nsb_pkg;
  localparam logic [4:0] ADDR_STATUS     = 5'h00;
  localparam logic [4:0] ADDR_DIR_E      = 5'h01;
  localparam logic [4:0] ADDR_DIR_A      = 5'h02;
  localparam logic [4:0] ADDR_VAL_A      = 5'h03;
  localparam logic [4:0] ADDR_OUT_C      = 5'h04;
  localparam logic [4:0] ADDR_DIR_B      = 5'h05;
  localparam logic [4:0] ADDR_VAL_B      = 5'h06;
  localparam logic [4:0] ADDR_SCRATCH1   = 5'h07;
  localparam logic [4:0] ADDR_AUD_EXT    = 5'h08;
  localparam logic [4:0] ADDR_AUD_CTRL   = 5'h09;
  localparam logic [4:0] ADDR_AUD_LOW    = 5'h0A;
  localparam logic [4:0] ADDR_AUD_HIGH   = 5'h0B;
  localparam logic [4:0] ADDR_DIR_D      = 5'h0C;
  localparam logic [4:0] ADDR_VAL_D      = 5'h0D;
  localparam logic [4:0] ADDR_VAL_E      = 5'h0E;
  localparam logic [4:0] ADDR_SCRATCH2   = 5'h0F;
  localparam logic [4:0] ADDR_TRIM       = 5'h10;
  localparam logic [4:0] ADDR_FORMAT     = 5'h11;
  localparam logic [4:0] ADDR_WAKE       = 5'h12;
  localparam logic [4:0] ADDR_DIRECT_MAX = 5'h0F;
  // Status fields.
  localparam int ZERO_BIT      = 0;
  localparam int CARRY_BIT     = 1;
  localparam int AUD_IRQ_BIT   = 2;
  // Audio control fields.
  localparam int AUD_EN_BIT    = 0;
  localparam int GIRQ_EN_BIT   = 1;
  // Format control fields.
  localparam int TWOS_BIT      = 1;
  localparam int GAIN_EN_BIT   = 3;
  // Trim fields.
  localparam int TRIM_LSB      = 0;
  localparam int GAIN_SEL_LSB  = 2;
  // Speaker wake fields.
  localparam int WAKE_EN_BIT   = 0;
  localparam int SENS_LSB      = 1;
  localparam int WAKE_FLAG_BIT = 3;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] NIB_UNMAPPED = 4'h0;
  localparam int SYNC_WIDTH    = 17;
  // Audio interrupt rate.
  localparam int CLK_HZ        = 20_000_000;
  localparam int IRQ_HZ_BASE   = 32768;
  localparam int IRQ_HZ_DOUBLE = 65536;
  localparam int IRQ_DIV_BASE   = CLK_HZ / IRQ_HZ_BASE;
  localparam int IRQ_DIV_DOUBLE = CLK_HZ / IRQ_HZ_DOUBLE;
  localparam logic [9:0] IRQ_CNT_BASE   = 10'(IRQ_DIV_BASE - 1);
  localparam logic [9:0] IRQ_CNT_DOUBLE = 10'(IRQ_DIV_DOUBLE - 1);
endpackage

/* hdl/nsb_audio_if.sv */
// Interface carrying the audio sample nibbles and the assembled sample between modules.
`timescale 1ns/1ps
interface nsb_audio_if;
  logic [3:0]  ext_nib;
  logic [3:0]  low_nib;
  logic [3:0]  high_nib;
  logic        ten_bit;
  logic        twelve_bit;
  logic        enable;
  logic [11:0] sample;
  logic        sign;
  modport bank (output ext_nib, output low_nib, output high_nib, output ten_bit,
                output twelve_bit, output enable, input sample, input sign);
  modport asm_side (input ext_nib, input low_nib, input high_nib, input ten_bit,
                    input twelve_bit, input enable, output sample, output sign);
endinterface

/* hdl/nsb_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module nsb_pin_sync
  import nsb_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic [SYNC_WIDTH-1:0] pin_in,
  output logic      [SYNC_WIDTH-1:0] pin_out
);
  logic [SYNC_WIDTH-1:0] s1_reg;
  logic [SYNC_WIDTH-1:0] s2_reg;
  logic [SYNC_WIDTH-1:0] s3_reg;

  always_ff @(posedge clk_sys)
  begin
    s1_reg <= pin_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  genvar i;
  generate
    for (i = 0; i < SYNC_WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          pin_out[i] <= 1'b0;
        else if (s2_reg[i] == s3_reg[i])
          pin_out[i] <= s3_reg[i];
      end
    end
  endgenerate
endmodule // nsb_pin_sync

/* hdl/nsb_sample_asm.sv */
// Assembles the 8, 10 or 12 bit audio sample from the three sample nibbles.
`timescale 1ns/1ps
module nsb_sample_asm
  import nsb_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  nsb_audio_if.asm_side aud
);
  logic [11:0] sample_next;

  always_comb
  begin
    // Twelve-bit choice overrides ten-bit; eight-bit ignores the extension.
    if (aud.twelve_bit)
      sample_next = {aud.high_nib, aud.low_nib, aud.ext_nib};
    else if (aud.ten_bit)
      sample_next = {aud.high_nib, aud.low_nib, aud.ext_nib[3:2], 2'h0};
    else
      sample_next = {aud.high_nib, aud.low_nib, 4'h0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      aud.sample <= 12'h000;
      aud.sign   <= 1'b0;
    end
    else if (aud.enable)
    begin
      aud.sample <= sample_next;
      aud.sign   <= aud.high_nib[3];
    end
  end
endmodule // nsb_sample_asm

/* hdl/nsb_reg_bank.sv */
// Nibble special function register bank with ports, audio sample and wake control.
`timescale 1ns/1ps
module nsb_reg_bank
  import nsb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [4:0]  cpu_addr,
  input  wire logic        cpu_wr_en,
  input  wire logic [3:0]  cpu_wr_data,
  input  wire logic        cpu_rd_en,
  output logic      [3:0]  cpu_rd_data,
  input  wire logic        bit_op_en,
  input  wire logic        bit_op_set,
  input  wire logic [1:0]  bit_op_index,
  input  wire logic        bit_op_indirect,
  input  wire logic        flags_wr_en,
  input  wire logic        zero_flag_in,
  input  wire logic        carry_flag_in,
  input  wire logic        bidir_port_ce_option,
  input  wire logic        port_e_mode_option,
  input  wire logic        ten_bit_audio_option,
  input  wire logic        twelve_bit_audio_option,
  input  wire logic        double_rate_irq_option,
  input  wire logic        osc_trim_option,
  input  wire logic [3:0]  port_a_pin_in,
  input  wire logic [3:0]  port_b_pin_in,
  input  wire logic [3:0]  port_d_pin_in,
  input  wire logic [3:0]  port_e_pin_in,
  input  wire logic        speaker_wake_pin,
  output logic      [3:0]  port_a_pin_out,
  output logic      [3:0]  port_a_pin_oe,
  output logic      [3:0]  port_b_pin_out,
  output logic      [3:0]  port_b_pin_oe,
  output logic      [3:0]  port_c_pin_out,
  output logic      [3:0]  port_d_pin_out,
  output logic      [3:0]  port_d_pin_oe,
  output logic      [3:0]  port_e_pin_out,
  output logic      [3:0]  port_e_pin_oe,
  output logic             zero_flag,
  output logic             carry_flag,
  output logic             audio_irq_req,
  output logic             audio_output_enable,
  output logic      [11:0] audio_sample,
  output logic             sample_sign_bit,
  output logic             twos_complement_select,
  output logic             record_gain_enable,
  output logic      [1:0]  record_gain_select,
  output logic      [1:0]  osc_trim_select,
  output logic      [1:0]  wake_sensitivity,
  output logic             speaker_wake_req
);
  logic [3:0] status_reg;
  logic [3:0] dir_e_reg, dir_a_reg, dir_b_reg, dir_d_reg;
  logic [3:0] lat_a_reg, lat_b_reg, lat_d_reg, lat_e_reg;
  logic [3:0] out_c_reg;
  logic [3:0] scratch1_reg;
  logic [3:0] scratch2_reg;
  logic [3:0] aud_ext_reg;
  logic [3:0] aud_low_reg;
  logic [3:0] aud_high_reg;
  logic [1:0] aud_ctrl_reg;
  logic [3:0] trim_reg;
  logic [3:0] format_reg;
  logic [3:0] wake_reg;
  logic [9:0] rate_cnt_reg;
  logic       rate_tick_reg;
  logic       wake_pin_d_reg;
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic [3:0] pin_a, pin_b, pin_d, pin_e;
  logic       wake_pin;
  logic       wake_event, bit_ok, wr_go;
  logic [3:0] wr_val;
  logic [3:0] bit_mask;

  nsb_audio_if aud_bus ();

  nsb_pin_sync u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin_in  ({speaker_wake_pin, port_e_pin_in, port_d_pin_in, port_b_pin_in, port_a_pin_in}),
    .pin_out (pins_sync)
  );

  assign pin_a    = pins_sync[3:0];
  assign pin_b    = pins_sync[7:4];
  assign pin_d    = pins_sync[11:8];
  assign pin_e    = pins_sync[15:12];
  assign wake_pin = pins_sync[16];

  // A readable value: port data registers return pins, write-only ones read as zero.
  function automatic logic [3:0] read_nib(input logic [4:0] a);
    case (a)
      ADDR_STATUS:   read_nib = status_reg;
      ADDR_DIR_E:    read_nib = dir_e_reg;
      ADDR_DIR_A:    read_nib = dir_a_reg;
      ADDR_VAL_A:    read_nib = pin_a;
      ADDR_OUT_C:    read_nib = out_c_reg;
      ADDR_DIR_B:    read_nib = dir_b_reg;
      ADDR_VAL_B:    read_nib = pin_b;
      ADDR_SCRATCH1: read_nib = scratch1_reg;
      ADDR_AUD_CTRL: read_nib = {2'h0, aud_ctrl_reg};
      ADDR_DIR_D:    read_nib = dir_d_reg;
      ADDR_VAL_D:    read_nib = pin_d;
      ADDR_VAL_E:    read_nib = pin_e;
      ADDR_SCRATCH2: read_nib = scratch2_reg;
      ADDR_TRIM:     read_nib = trim_reg;
      ADDR_FORMAT:   read_nib = format_reg;
      ADDR_WAKE:     read_nib = wake_reg;
      default:       read_nib = NIB_UNMAPPED;
    endcase
  endfunction

  always_comb
  begin
    bit_mask = 4'h1 << bit_op_index;
    // Direct bit operations stop at 0FH; above it only indirect ones pass.
    bit_ok = bit_op_en && (bit_op_indirect || (cpu_addr <= ADDR_DIRECT_MAX));
    wr_go  = cpu_wr_en || bit_ok;
    if (bit_ok)
      wr_val = bit_op_set ? (read_nib(cpu_addr) | bit_mask)
                          : (read_nib(cpu_addr) & ~bit_mask);
    else
      wr_val = cpu_wr_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      cpu_rd_data <= NIB_RESET;
    else if (cpu_rd_en)
      cpu_rd_data <= read_nib(cpu_addr);
  end

  // Interrupt rate divider; the tick period follows the double-rate option.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rate_cnt_reg  <= 10'h000;
      rate_tick_reg <= 1'b0;
    end
    else if (rate_cnt_reg >= (double_rate_irq_option ? IRQ_CNT_DOUBLE : IRQ_CNT_BASE))
    begin
      rate_cnt_reg  <= 10'h000;
      rate_tick_reg <= 1'b1;
    end
    else
    begin
      rate_cnt_reg  <= rate_cnt_reg + 10'h001;
      rate_tick_reg <= 1'b0;
    end
  end

  // Status: core flag updates and software writes; the tick beats a clear.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      status_reg <= NIB_RESET;
    else
    begin
      if (wr_go && cpu_addr == ADDR_STATUS)
        status_reg[2:0] <= wr_val[2:0];
      if (flags_wr_en)
      begin
        status_reg[ZERO_BIT]  <= zero_flag_in;
        status_reg[CARRY_BIT] <= carry_flag_in;
      end
      if (rate_tick_reg)
        status_reg[AUD_IRQ_BIT] <= 1'b1;
      status_reg[3] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      dir_e_reg  <= NIB_RESET;
      dir_a_reg  <= NIB_RESET;
      dir_b_reg  <= NIB_RESET;
      dir_d_reg  <= NIB_RESET;
      out_c_reg  <= NIB_RESET;
      aud_ctrl_reg <= 2'h0;
      trim_reg   <= NIB_RESET;
      format_reg <= NIB_RESET;
    end
    else if (wr_go)
    begin
      case (cpu_addr)
        ADDR_DIR_E:    dir_e_reg <= wr_val;
        ADDR_DIR_A:    dir_a_reg <= wr_val;
        ADDR_DIR_B:    dir_b_reg <= wr_val;
        ADDR_DIR_D:    dir_d_reg <= wr_val;
        ADDR_OUT_C:    out_c_reg <= wr_val;
        ADDR_AUD_CTRL: aud_ctrl_reg <= wr_val[1:0];
        ADDR_TRIM:     trim_reg <= wr_val;
        ADDR_FORMAT:   format_reg <= {wr_val[GAIN_EN_BIT], 1'b0, wr_val[TWOS_BIT], 1'b0};
        default:       ;
      endcase
    end
  end

  // Output latches, scratch and sample nibbles carry no reset, as their contents
  // are undefined at start-up; port latches only matter once a pin is an output.
  always_ff @(posedge clk_sys)
  begin
    if (wr_go)
    begin
      case (cpu_addr)
        ADDR_VAL_A:    lat_a_reg <= wr_val;
        ADDR_VAL_B:    lat_b_reg <= wr_val;
        ADDR_VAL_D:    lat_d_reg <= wr_val;
        ADDR_VAL_E:    lat_e_reg <= wr_val;
        ADDR_SCRATCH1: scratch1_reg <= wr_val;
        ADDR_SCRATCH2: scratch2_reg <= wr_val;
        ADDR_AUD_EXT:  aud_ext_reg <= wr_val;
        ADDR_AUD_LOW:  aud_low_reg <= wr_val;
        ADDR_AUD_HIGH: aud_high_reg <= wr_val;
        default:       ;
      endcase
    end
  end

  // Speaker wake: a rising edge of the filtered pin sets the flag when enabled.
  assign wake_event = wake_pin && !wake_pin_d_reg && wake_reg[WAKE_EN_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wake_reg       <= NIB_RESET;
      wake_pin_d_reg <= 1'b0;
    end
    else
    begin
      wake_pin_d_reg <= wake_pin;
      if (wr_go && cpu_addr == ADDR_WAKE)
        wake_reg <= wr_val;
      if (wake_event)
        wake_reg[WAKE_FLAG_BIT] <= 1'b1;
    end
  end

  assign aud_bus.ext_nib    = aud_ext_reg;
  assign aud_bus.low_nib    = aud_low_reg;
  assign aud_bus.high_nib   = aud_high_reg;
  assign aud_bus.ten_bit    = ten_bit_audio_option;
  assign aud_bus.twelve_bit = twelve_bit_audio_option;
  assign aud_bus.enable     = aud_ctrl_reg[AUD_EN_BIT];
  assign audio_sample       = aud_bus.sample;
  assign sample_sign_bit    = aud_bus.sign;

  nsb_sample_asm u_asm (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .aud     (aud_bus.asm_side)
  );

  // Pin and control outputs, all registered.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      port_a_pin_out <= NIB_RESET;
      port_a_pin_oe  <= NIB_RESET;
      port_b_pin_out <= NIB_RESET;
      port_b_pin_oe  <= NIB_RESET;
      port_c_pin_out <= NIB_RESET;
      port_d_pin_out <= NIB_RESET;
      port_d_pin_oe  <= NIB_RESET;
      port_e_pin_out <= NIB_RESET;
      port_e_pin_oe  <= NIB_RESET;
      zero_flag      <= 1'b0;
      carry_flag     <= 1'b0;
      audio_irq_req  <= 1'b0;
      audio_output_enable    <= 1'b0;
      twos_complement_select <= 1'b0;
      record_gain_enable     <= 1'b0;
      record_gain_select     <= 2'h0;
      osc_trim_select        <= 2'h0;
      wake_sensitivity       <= 2'h0;
      speaker_wake_req       <= 1'b0;
    end
    else
    begin
      port_a_pin_out <= lat_a_reg & dir_a_reg;
      port_a_pin_oe  <= dir_a_reg;
      port_b_pin_out <= lat_b_reg & dir_b_reg;
      port_b_pin_oe  <= dir_b_reg;
      port_c_pin_out <= out_c_reg;
      port_d_pin_out <= lat_d_reg & dir_d_reg;
      port_d_pin_oe  <= dir_d_reg;
      // Without either option port E stays input only, so direction bits are moot.
      port_e_pin_oe  <= (bidir_port_ce_option || port_e_mode_option) ? dir_e_reg : 4'h0;
      port_e_pin_out <= lat_e_reg & dir_e_reg;
      zero_flag      <= status_reg[ZERO_BIT];
      carry_flag     <= status_reg[CARRY_BIT];
      audio_irq_req  <= status_reg[AUD_IRQ_BIT] && aud_ctrl_reg[GIRQ_EN_BIT];
      audio_output_enable    <= aud_ctrl_reg[AUD_EN_BIT];
      twos_complement_select <= format_reg[TWOS_BIT];
      record_gain_enable     <= format_reg[GAIN_EN_BIT];
      record_gain_select     <= format_reg[GAIN_EN_BIT] ? trim_reg[3:2] : 2'h0;
      osc_trim_select        <= osc_trim_option ? trim_reg[1:0] : 2'h0;
      wake_sensitivity       <= wake_reg[2:1];
      speaker_wake_req       <= wake_reg[WAKE_FLAG_BIT];
    end
  end

  // Checks.
  a_direct_bit_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bit_op_en && !bit_op_indirect && !cpu_wr_en && cpu_addr == ADDR_TRIM)
    |=> trim_reg == $past(trim_reg))
    else $error("Direct bit operation changed a register above 0FH.");
  a_tick_sets_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    rate_tick_reg |=> status_reg[AUD_IRQ_BIT])
    else $error("Audio interrupt flag not set after rate tick.");
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rate_tick_reg && !double_rate_irq_option) |=> !rate_tick_reg [*8])
    else $error("Rate ticks too close together.");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!aud_ctrl_reg[GIRQ_EN_BIT] && $stable(aud_ctrl_reg)) |=> !audio_irq_req)
    else $error("Interrupt request raised while globally disabled.");
  a_portc_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cpu_wr_en && !bit_op_en && cpu_addr == ADDR_OUT_C) |=> ##1 port_c_pin_out == $past(cpu_wr_data, 2))
    else $error("Port C pins do not follow the written value.");
  a_wake_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    wake_event |=> wake_reg[WAKE_FLAG_BIT] ##1 speaker_wake_req)
    else $error("Speaker wake flag not raised.");
  a_wake_disabled: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!wake_reg[WAKE_EN_BIT] && !wr_go && !wake_reg[WAKE_FLAG_BIT]) |=> !wake_reg[WAKE_FLAG_BIT])
    else $error("Wake flag set while speaker wake disabled.");
  a_dir_to_oe: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cpu_wr_en && !bit_op_en && cpu_addr == ADDR_DIR_A) |=> ##1 port_a_pin_oe == $past(cpu_wr_data, 2))
    else $error("Port A enables do not follow the direction write.");
  a_trim_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
    !osc_trim_option |=> osc_trim_select == 2'h0)
    else $error("Trim select output while trim option is off.");
  c_irq_taken: cover property (@(posedge clk_sys) disable iff (!nrst) audio_irq_req);
  c_wake_seen: cover property (@(posedge clk_sys) disable iff (!nrst) wake_event);
  c_bit_op_hi: cover property (@(posedge clk_sys) disable iff (!nrst)
    bit_op_en && bit_op_indirect && cpu_addr == ADDR_WAKE);
endmodule // nsb_reg_bank

/* test/nsb_reg_bank_tb.sv */
// Self-checking testbench for the nibble register bank.
`timescale 1ns/1ps
module nsb_reg_bank_tb
  import nsb_pkg::*;
();
  typedef struct packed {logic [4:0] a; logic [3:0] w; logic [3:0] e;} nsb_row_type;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  cpu_addr = 5'h00;
  logic [3:0]  cpu_wr_data = 4'h0;
  logic        cpu_wr_en = 1'b0, cpu_rd_en = 1'b0, bit_op_en = 1'b0, bit_op_set = 1'b0;
  logic [1:0]  bit_op_index = 2'h0;
  logic        bit_op_indirect = 1'b0, flags_wr_en = 1'b0;
  logic        zero_flag_in = 1'b0, carry_flag_in = 1'b0, speaker_wake_pin = 1'b0;
  logic        bidir_port_ce_option = 1'b1, port_e_mode_option = 1'b0;
  logic        ten_bit_audio_option = 1'b0, twelve_bit_audio_option = 1'b0;
  logic        double_rate_irq_option = 1'b0, osc_trim_option = 1'b1;
  logic [3:0]  port_a_pin_in = 4'h3, port_b_pin_in = 4'hB;
  logic [3:0]  port_d_pin_in = 4'h6, port_e_pin_in = 4'h9;
  logic [3:0]  cpu_rd_data, port_a_pin_out, port_a_pin_oe, port_b_pin_out, port_b_pin_oe;
  logic [3:0]  port_c_pin_out, port_d_pin_out, port_d_pin_oe, port_e_pin_out, port_e_pin_oe;
  logic        zero_flag, carry_flag, audio_irq_req, audio_output_enable, sample_sign_bit;
  logic        twos_complement_select, record_gain_enable, speaker_wake_req;
  logic [11:0] audio_sample;
  logic [1:0]  record_gain_select, osc_trim_select, wake_sensitivity;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [3:0]  d;
  logic [4:0]  zero_addr [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h0C, 5'h10, 5'h11, 5'h12};
  nsb_row_type rows [19] = '{
    '{5'h01, 4'hA, 4'hA}, '{5'h02, 4'hF, 4'hF}, '{5'h03, 4'h5, 4'h3}, '{5'h04, 4'h9, 4'h9},
    '{5'h05, 4'hC, 4'hC}, '{5'h06, 4'h2, 4'hB}, '{5'h07, 4'h6, 4'h6}, '{5'h08, 4'hF, 4'h0},
    '{5'h09, 4'hF, 4'h3}, '{5'h0A, 4'h7, 4'h0}, '{5'h0B, 4'h8, 4'h0}, '{5'h0C, 4'h5, 4'h5},
    '{5'h0D, 4'h1, 4'h6}, '{5'h0E, 4'hE, 4'h9}, '{5'h0F, 4'hE, 4'hE}, '{5'h10, 4'hE, 4'hE},
    // No option gates the format bits, so software may turn record gain on.
    '{5'h11, 4'hF, 4'hA}, '{5'h12, 4'h6, 4'h6}, '{5'h13, 4'hF, 4'h0}};

  nsb_reg_bank uut (.*);

  always #25 clk_sys = ~clk_sys;

  task automatic chk(string name, logic [11:0] seen, logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic wr(logic [4:0] a, logic [3:0] w);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wr_data <= w;
    cpu_wr_en <= 1'b1;
    @(posedge clk_sys);
    cpu_wr_en <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a, output logic [3:0] q);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd_en <= 1'b1;
    @(posedge clk_sys);
    cpu_rd_en <= 1'b0;
    @(negedge clk_sys);
    q = cpu_rd_data;
  endtask

  task automatic bop(logic [4:0] a, logic s, logic [1:0] i, logic ind);
    @(posedge clk_sys);
    cpu_addr <= a;
    bit_op_set <= s;
    bit_op_index <= i;
    bit_op_indirect <= ind;
    bit_op_en <= 1'b1;
    @(posedge clk_sys);
    bit_op_en <= 1'b0;
    settle();
  endtask

  // The bound sits well above one slow interrupt period, so a stuck flag is caught.
  task automatic wait_req(output time t);
    int n;
    n = 0;
    while (audio_irq_req !== 1'b1 && n < 1000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("irq wait bound", 12'(n < 1000), 12'h001);
    t = $time;
  endtask

  // Measuring between two fresh rises avoids counting a flag that was already pending.
  task automatic rate(int exp);
    time t1;
    time t2;
    wait_req(t1);
    bop(ADDR_STATUS, 1'b0, 2'(AUD_IRQ_BIT), 1'b0);
    wait_req(t1);
    bop(ADDR_STATUS, 1'b0, 2'(AUD_IRQ_BIT), 1'b0);
    wait_req(t2);
    chk("irq period", 12'((t2 - t1) / 50), 12'(exp));
  endtask

  initial
  begin
    #(20000 * 50);
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (zero_addr[i])
    begin
      rd(zero_addr[i], d);
      chk("reset value", 12'(d), 12'h000);
    end
    chk("port c after reset", 12'(port_c_pin_out), 12'h000);
    $display("test done: reset values");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("register readback", 12'(d), 12'(rows[i].e));
    end
    settle();
    chk("port a out", 12'(port_a_pin_out), 12'h005);
    chk("port a oe", 12'(port_a_pin_oe), 12'h00F);
    chk("port b out", 12'(port_b_pin_out), 12'h000);
    chk("port b oe", 12'(port_b_pin_oe), 12'h00C);
    chk("port d out", 12'(port_d_pin_out), 12'h001);
    chk("port d oe", 12'(port_d_pin_oe), 12'h005);
    chk("port c out", 12'(port_c_pin_out), 12'h009);
    chk("port e oe", 12'(port_e_pin_oe), 12'h00A);
    chk("port e out", 12'(port_e_pin_out), 12'h00A);
    chk("format", 12'({twos_complement_select, record_gain_enable}), 12'h003);
    chk("gain select", 12'(record_gain_select), 12'h003);
    chk("trim select", 12'(osc_trim_select), 12'h002);
    chk("sensitivity", 12'(wake_sensitivity), 12'h003);
    chk("audio enable", 12'(audio_output_enable), 12'h001);
    @(posedge clk_sys);
    bidir_port_ce_option <= 1'b0;
    osc_trim_option <= 1'b0;
    settle();
    chk("port e oe off", 12'(port_e_pin_oe), 12'h000);
    chk("trim select off", 12'(osc_trim_select), 12'h000);
    $display("test done: register table");
    wr(ADDR_AUD_EXT, 4'hD);
    wr(ADDR_AUD_LOW, 4'h5);
    wr(ADDR_AUD_HIGH, 4'hA);
    settle();
    chk("sample 8 bit", audio_sample, 12'hA50);
    chk("sign bit", 12'(sample_sign_bit), 12'h001);
    @(posedge clk_sys);
    ten_bit_audio_option <= 1'b1;
    settle();
    chk("sample 10 bit", audio_sample, 12'hA5C);
    @(posedge clk_sys);
    twelve_bit_audio_option <= 1'b1;
    settle();
    chk("sample 12 bit", audio_sample, 12'hA5D);
    $display("test done: audio sample");
    bop(ADDR_SCRATCH1, 1'b1, 2'h0, 1'b0);
    rd(ADDR_SCRATCH1, d);
    chk("direct set", 12'(d), 12'h007);
    bop(ADDR_TRIM, 1'b0, 2'h3, 1'b0);
    rd(ADDR_TRIM, d);
    chk("direct high refused", 12'(d), 12'h00E);
    bop(ADDR_TRIM, 1'b0, 2'h3, 1'b1);
    rd(ADDR_TRIM, d);
    chk("indirect high", 12'(d), 12'h006);
    @(posedge clk_sys);
    flags_wr_en <= 1'b1;
    zero_flag_in <= 1'b1;
    carry_flag_in <= 1'b1;
    @(posedge clk_sys);
    flags_wr_en <= 1'b0;
    settle();
    chk("flag outputs", 12'({zero_flag, carry_flag}), 12'h003);
    rd(ADDR_STATUS, d);
    chk("status flags", 12'({d[3], d[1:0]}), 12'h003);
    $display("test done: bit operations");
    wr(ADDR_WAKE, 4'h1);
    @(posedge clk_sys);
    speaker_wake_pin <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("wake request", 12'(speaker_wake_req), 12'h001);
    rd(ADDR_WAKE, d);
    chk("wake flag", 12'(d), 12'h009);
    wr(ADDR_WAKE, 4'h0);
    @(posedge clk_sys);
    speaker_wake_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    speaker_wake_pin <= 1'b1;
    repeat (8) @(negedge clk_sys);
    rd(ADDR_WAKE, d);
    chk("wake disabled", 12'(d), 12'h000);
    $display("test done: speaker wake");
    rate(IRQ_DIV_BASE);
    wr(ADDR_AUD_CTRL, 4'h1);
    repeat (700) @(negedge clk_sys);
    chk("irq masked", 12'(audio_irq_req), 12'h000);
    rd(ADDR_STATUS, d);
    chk("irq flag pending", 12'(d[2]), 12'h001);
    @(posedge clk_sys);
    nrst <= 1'b0;
    double_rate_irq_option <= 1'b1;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(ADDR_DIR_A, d);
    chk("dir after reset", 12'(d), 12'h000);
    wr(ADDR_AUD_CTRL, 4'h2);
    rate(IRQ_DIV_DOUBLE);
    $display("test done: interrupt rate");
    give_verdict();
  end
endmodule // nsb_reg_bank_tb
